// [iafsf_asserts.sv]
`timescale 1ns/10ps
module iafsf_asserts #(
    parameter int FIFO_DEPTH = 32
) (
    input wire logic       CLK,
    input wire logic       RST_N,
    input wire logic       SET_DEFAULT,
    input wire logic       FIFO_CLEAR,
    input wire logic       REG_RD,
    input wire logic [4:0] REG_ADDR,
    input wire logic       FIFO_PUSH,
    input wire logic       FIFO_POP,
    input wire logic       RX_PARITY_ERR,
    input wire logic       RX_CRC_ERR,
    input wire logic       RX_FRAMING_ERR,
    input wire logic       RX_NO_PARITY,
    input wire logic       RX_FRAME_END,
    input wire logic       DESELECT_RX,
    input wire logic       NVM_WR_DONE,
    input wire logic       NVM_WR_FAULT,
    input wire logic       NVM_ABORTED,
    input wire logic       MASK_WR,
    input wire logic [7:0] RDATA,
    input wire logic       AUX_PENDING
);
    // ---------------------------------------------------------------
    // Any source that may set a flag
    // ---------------------------------------------------------------
    logic evt;
    logic rd_aux;
    assign evt = RX_PARITY_ERR | RX_CRC_ERR | RX_FRAMING_ERR | RX_NO_PARITY
               | RX_FRAME_END | DESELECT_RX | NVM_WR_DONE | NVM_WR_FAULT
               | NVM_ABORTED | FIFO_PUSH | FIFO_POP;
    assign rd_aux = REG_RD && REG_ADDR == 5'h0B;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);
    a_aux_read_clear: assert property (rd_aux && !evt ##1 !evt |=>
        !AUX_PENDING) else $error("pending stays after aux read");
    a_parity_flag: assert property (RX_PARITY_ERR && !SET_DEFAULT ##1
        (!SET_DEFAULT && !rd_aux) ##1 rd_aux |=> RDATA[5])
        else $error("parity flag missing");
    a_event_kept: assert property (rd_aux && RX_CRC_ERR && !SET_DEFAULT
        ##1 (!SET_DEFAULT && !rd_aux) ##1 rd_aux |=> RDATA[4])
        else $error("event lost on read");
    a_default_clear: assert property (SET_DEFAULT && !evt ##1 !evt
        ##1 rd_aux |=> RDATA == 8'h00)
        else $error("aux flags kept on defaults");
    a_fill_clear: assert property (FIFO_CLEAR && !FIFO_PUSH ##1
        !FIFO_PUSH ##1 (REG_RD && REG_ADDR == 5'h0C) |=> RDATA == 8'h00)
        else $error("fill count kept on clear");
    a_fill_range: assert property (REG_RD && REG_ADDR == 5'h0C |=>
        RDATA <= FIFO_DEPTH) else $error("fill count out of range");
    a_pending_cause: assert property ($rose(AUX_PENDING) |->
        $past(evt) || $past(evt, 2) || $past(MASK_WR) || $past(MASK_WR, 2))
        else $error("pending without cause");
    a_missing_parity: assert property (RX_NO_PARITY && !SET_DEFAULT
        && !FIFO_CLEAR ##1 (!SET_DEFAULT && !FIFO_CLEAR)
        ##1 (REG_RD && REG_ADDR == 5'h0D) |=> RDATA[0])
        else $error("missing parity not flagged");
endmodule : iafsf_asserts
bind iafsf_top iafsf_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) iafsf_asserts_inst (.*);

// [iafsf_evt_if.sv]
`timescale 1ns/10ps
interface iafsf_evt_if;
    logic [7:0] set_vec;
    logic       clr_all;
    logic       rd_clr;
    logic [7:0] flags;
    modport owner (input set_vec, input clr_all, input rd_clr,
                   output flags);
    modport user  (output set_vec, output clr_all, output rd_clr,
                   input flags);
endinterface : iafsf_evt_if

// [iafsf_host_model.sv]
`timescale 1ns/10ps
module iafsf_host_model (
    input  wire logic       clk,
    output logic            reg_rd,
    output logic [4:0]      reg_addr,
    input  wire logic [7:0] rdata
);
    // ---------------------------------------------------------------
    // Register read: strobe one cycle, data a cycle later
    // ---------------------------------------------------------------
    initial begin
        reg_rd   = 1'b0;
        reg_addr = 5'h00;
    end
    task automatic read(input logic [4:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd   = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d        = rdata;
    endtask : read
endmodule : iafsf_host_model

// [iafsf_pkg.sv]
package iafsf_pkg;
    // ---------------------------------------------------------------
    // Register addresses
    // ---------------------------------------------------------------
    localparam logic [4:0] ADDR_MAIN_IRQ  = 5'h00;
    localparam logic [4:0] ADDR_AUX_MASK  = 5'h09;
    localparam logic [4:0] ADDR_AUX_IRQ   = 5'h0B;
    localparam logic [4:0] ADDR_FIFO_CNT  = 5'h0C;
    localparam logic [4:0] ADDR_FIFO_ERR  = 5'h0D;
    // ---------------------------------------------------------------
    // Auxiliary flag positions
    // ---------------------------------------------------------------
    localparam int AUX_DESELECT  = 7;
    localparam int AUX_FRAMING   = 6;
    localparam int AUX_PARITY    = 5;
    localparam int AUX_CHECKSUM  = 4;
    localparam int AUX_BUFFER    = 3;
    localparam int AUX_NVM_DONE  = 2;
    localparam int AUX_NVM_FAULT = 1;
    localparam int AUX_NVM_ABORT = 0;
    // ---------------------------------------------------------------
    // Second FIFO status and main register bit positions
    // ---------------------------------------------------------------
    localparam int FS2_UNDERFLOW = 6;
    localparam int FS2_OVERFLOW  = 5;
    localparam int FS2_PARTIAL   = 4;
    localparam int FS2_BITS_MSB  = 3;
    localparam int FS2_BITS_LSB  = 1;
    localparam int FS2_NO_PARITY = 0;
    localparam int MAIN_AUX_BIT  = 0;
    // ---------------------------------------------------------------
    // Reset values and limits
    // ---------------------------------------------------------------
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam int         FIFO_DEPTH = 32;
    localparam int         CNT_W      = 6;
endpackage : iafsf_pkg

// [iafsf_sticky.sv]
`timescale 1ns/10ps
module iafsf_sticky (
    input  wire logic        clk,
    input  wire logic        rst_n,
    iafsf_evt_if.owner       evt
);
    logic [7:0] flags_ff;
    logic [7:0] nxt_flags;

    // ---------------------------------------------------------------
    // Sticky flags, set beats read clear; clear-all beats set
    // ---------------------------------------------------------------
    always_comb begin
        if (evt.clr_all) begin
            nxt_flags = iafsf_pkg::RESET_BYTE;
        end else if (evt.rd_clr) begin
            nxt_flags = evt.set_vec;
        end else begin
            nxt_flags = flags_ff | evt.set_vec;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_ff <= iafsf_pkg::RESET_BYTE;
        end else begin
            flags_ff <= nxt_flags;
        end
    end

    assign evt.flags = flags_ff;
endmodule : iafsf_sticky

// [iafsf_top.sv]
// Function
// - Main interrupt register clears at power-up and restore-defaults.
// - Main read clears nothing; bits 7..1 read 0; bit0 clears on auxiliary read.
// - Auxiliary register at 0Bh is read-only with eight event flags.
// - Parity or CRC faulty data still goes to FIFO, flag raised.
// - NVM done flag only for host-port writes that succeed.
// - NVM fault flag for host writes to protected or missing words.
// - Abort flag when card interface interrupts host NVM access.
// - Auxiliary register clears at reset, defaults and after each read.
// - Register 0Ch gives unread FIFO bytes 0..32 in bits 5..0.
// - Underflow bit 6 of 0Dh when host reads past FIFO content.
// - Auxiliary bit 3 flags FIFO overflow or underflow; overflow bit 5.
// - Bit 4 of 0Dh set when last FIFO byte is partial.
// - Bits 3..1 give valid bit count of partial last byte.
// - Bit 0 of 0Dh flags missing parity; counts as framing error.
// - Main bit0 set while any unmasked auxiliary event is pending.
// - Mask register 09h; set bit suppresses that event's interrupt.
`timescale 1ns/10ps
module iafsf_top #(
    parameter int FIFO_DEPTH = iafsf_pkg::FIFO_DEPTH
) (
    input  wire logic       CLK,
    input  wire logic       RST_N,
    input  wire logic       SET_DEFAULT,
    input  wire logic       FIFO_CLEAR,
    input  wire logic       REG_RD,
    input  wire logic [4:0] REG_ADDR,
    input  wire logic       MAIN_RD_CLR,
    input  wire logic       FIFO_PUSH,
    input  wire logic       FIFO_POP,
    input  wire logic       RX_PARITY_ERR,
    input  wire logic       RX_CRC_ERR,
    input  wire logic       RX_FRAMING_ERR,
    input  wire logic       RX_NO_PARITY,
    input  wire logic       RX_FRAME_END,
    input  wire logic [2:0] RX_LAST_BITS,
    input  wire logic       DESELECT_RX,
    input  wire logic       NVM_WR_DONE,
    input  wire logic       NVM_WR_FAULT,
    input  wire logic       NVM_WR_FROM_HOST,
    input  wire logic       NVM_ABORTED,
    input  wire logic       MASK_WR,
    input  wire logic [7:0] MASK_WDATA,
    output logic [7:0]      RDATA,
    output logic            AUX_PENDING,
    output logic            FIFO_PUSH_OK,
    output logic            FIFO_POP_OK
);
    // ---------------------------------------------------------------
    // Parameter check
    // ---------------------------------------------------------------
    if (FIFO_DEPTH < 1 || FIFO_DEPTH > 63) begin : g_bad_depth
        $error("FIFO_DEPTH outside 1..63");
    end

    localparam logic [5:0] DEPTH = 6'(FIFO_DEPTH);

    function automatic logic [7:0] fs2_pack(
        input logic       unf,
        input logic       ovr,
        input logic       part,
        input logic [2:0] bits,
        input logic       nopar
    );
        fs2_pack = {1'b0, unf, ovr, part, bits, nopar};
    endfunction : fs2_pack

    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    logic [5:0] cnt_ff,   nxt_cnt;
    logic       unf_ff,   nxt_unf;
    logic       ovr_ff,   nxt_ovr;
    logic       part_ff,  nxt_part;
    logic [2:0] bits_ff,  nxt_bits;
    logic       nopar_ff, nxt_nopar;
    logic [7:0] mask_ff,  nxt_mask;
    logic [7:0] rdata_ff, nxt_rdata;
    logic       pend_ff,  nxt_pend;
    logic       push_ok_ff, nxt_push_ok;
    logic       pop_ok_ff,  nxt_pop_ok;
    logic       clr_fifo;
    logic       aux_rd;
    logic       over_ev;
    logic       under_ev;

    iafsf_evt_if aux_evt ();

    iafsf_sticky u_aux (
        .clk   (CLK),
        .rst_n (RST_N),
        .evt   (aux_evt)
    );

    // ---------------------------------------------------------------
    // Event gathering
    // ---------------------------------------------------------------
    always_comb begin
        clr_fifo = SET_DEFAULT | FIFO_CLEAR;
        aux_rd   = REG_RD && (REG_ADDR == iafsf_pkg::ADDR_AUX_IRQ);
        over_ev  = FIFO_PUSH && !FIFO_POP && (cnt_ff == DEPTH);
        under_ev = FIFO_POP && !FIFO_PUSH && (cnt_ff == 6'h00);
        aux_evt.set_vec = 8'h00;
        aux_evt.set_vec[iafsf_pkg::AUX_DESELECT]  = DESELECT_RX;
        aux_evt.set_vec[iafsf_pkg::AUX_FRAMING]   =
            RX_FRAMING_ERR | RX_NO_PARITY;
        aux_evt.set_vec[iafsf_pkg::AUX_PARITY]    = RX_PARITY_ERR;
        aux_evt.set_vec[iafsf_pkg::AUX_CHECKSUM]  = RX_CRC_ERR;
        aux_evt.set_vec[iafsf_pkg::AUX_BUFFER]    = over_ev | under_ev;
        aux_evt.set_vec[iafsf_pkg::AUX_NVM_DONE]  =
            NVM_WR_DONE & NVM_WR_FROM_HOST;
        aux_evt.set_vec[iafsf_pkg::AUX_NVM_FAULT] =
            NVM_WR_FAULT & NVM_WR_FROM_HOST;
        aux_evt.set_vec[iafsf_pkg::AUX_NVM_ABORT] = NVM_ABORTED;
        aux_evt.clr_all = SET_DEFAULT;
        aux_evt.rd_clr  = aux_rd;
    end

    // ---------------------------------------------------------------
    // FIFO status next state
    // ---------------------------------------------------------------
    always_comb begin
        nxt_cnt   = cnt_ff;
        nxt_unf   = unf_ff | under_ev;
        nxt_ovr   = ovr_ff | over_ev;
        nxt_part  = part_ff;
        nxt_bits  = bits_ff;
        nxt_nopar = nopar_ff | RX_NO_PARITY;
        // Data of faulty frames is still counted
        if (FIFO_PUSH && !FIFO_POP && cnt_ff != DEPTH) begin
            nxt_cnt = cnt_ff + 6'h01;
        end else if (FIFO_POP && !FIFO_PUSH && cnt_ff != 6'h00) begin
            nxt_cnt = cnt_ff - 6'h01;
        end
        if (RX_FRAME_END) begin
            nxt_part = (RX_LAST_BITS != 3'h0);
            nxt_bits = RX_LAST_BITS;
        end
        if (clr_fifo) begin
            nxt_cnt   = 6'h00;
            nxt_unf   = 1'b0;
            nxt_ovr   = 1'b0;
            nxt_part  = 1'b0;
            nxt_bits  = 3'h0;
            nxt_nopar = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Mask, summary and read data
    // ---------------------------------------------------------------
    always_comb begin
        nxt_mask = SET_DEFAULT ? iafsf_pkg::RESET_BYTE :
                   (MASK_WR ? MASK_WDATA : mask_ff);
        // Summary follows unmasked pending flags; falls on aux read
        nxt_pend = |(aux_evt.flags & ~mask_ff);
        if (aux_rd) begin
            nxt_pend = |(aux_evt.set_vec & ~mask_ff);
        end
        if (SET_DEFAULT) begin
            nxt_pend = 1'b0;
        end
        nxt_push_ok = (cnt_ff < DEPTH);
        nxt_pop_ok  = (cnt_ff != 6'h00);
        nxt_rdata = rdata_ff;
        if (REG_RD) begin
            unique case (REG_ADDR)
                iafsf_pkg::ADDR_MAIN_IRQ: nxt_rdata = {7'h00, pend_ff};
                iafsf_pkg::ADDR_AUX_MASK: nxt_rdata = mask_ff;
                iafsf_pkg::ADDR_AUX_IRQ:  nxt_rdata = aux_evt.flags;
                iafsf_pkg::ADDR_FIFO_CNT: nxt_rdata = {2'h0, cnt_ff};
                iafsf_pkg::ADDR_FIFO_ERR: nxt_rdata =
                    fs2_pack(unf_ff, ovr_ff, part_ff, bits_ff, nopar_ff);
                default:                  nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt_ff     <= 6'h00;
            unf_ff     <= 1'b0;
            ovr_ff     <= 1'b0;
            part_ff    <= 1'b0;
            bits_ff    <= 3'h0;
            nopar_ff   <= 1'b0;
            mask_ff    <= iafsf_pkg::RESET_BYTE;
            rdata_ff   <= 8'h00;
            pend_ff    <= 1'b0;
            push_ok_ff <= 1'b1;
            pop_ok_ff  <= 1'b0;
        end else begin
            cnt_ff     <= nxt_cnt;
            unf_ff     <= nxt_unf;
            ovr_ff     <= nxt_ovr;
            part_ff    <= nxt_part;
            bits_ff    <= nxt_bits;
            nopar_ff   <= nxt_nopar;
            mask_ff    <= nxt_mask;
            rdata_ff   <= nxt_rdata;
            pend_ff    <= nxt_pend;
            push_ok_ff <= nxt_push_ok;
            pop_ok_ff  <= nxt_pop_ok;
        end
    end

    assign RDATA        = rdata_ff;
    assign AUX_PENDING  = pend_ff;
    assign FIFO_PUSH_OK = push_ok_ff;
    assign FIFO_POP_OK  = pop_ok_ff;
endmodule : iafsf_top

// [irq_and_fifo_status_flags_tb_top.sv]
`timescale 1ns/10ps
module irq_and_fifo_status_flags_tb_top;
    // ---------------------------------------------------------------
    // Stimulus, one event bit per strobe input
    // ---------------------------------------------------------------
    localparam logic [14:0] EV_TBL [8] = '{15'h0010, 15'h0004, 15'h0001,
        15'h0002, 15'h0200, 15'h0020, 15'h0040, 15'h0080};
    localparam logic [7:0]  FL_TBL [8] = '{8'h80, 8'h40, 8'h20, 8'h10,
        8'h08, 8'h04, 8'h02, 8'h01};
    logic        clk      = 1'b0;
    logic        rst_n    = 1'b0;
    logic [14:0] ev       = '0;
    logic        host_lvl = 1'b1;
    logic [2:0]  lb       = 3'h0;
    logic [7:0]  mw       = 8'h00;
    logic [7:0]  d;
    wire  logic       reg_rd;
    wire  logic [4:0] reg_addr;
    wire  logic [7:0] rdata;
    wire  logic       pend;
    wire  logic       push_ok;
    wire  logic       pop_ok;
    int          bad_count  = 0;
    int          n_compared = 0;
    always #2.5 clk = ~clk;
    iafsf_top #(.FIFO_DEPTH(32)) iafsf_top_inst (
        .CLK(clk), .RST_N(rst_n), .SET_DEFAULT(ev[11]),
        .FIFO_CLEAR(ev[12]), .REG_RD(reg_rd), .REG_ADDR(reg_addr),
        .MAIN_RD_CLR(ev[14]), .FIFO_PUSH(ev[8]), .FIFO_POP(ev[9]),
        .RX_PARITY_ERR(ev[0]), .RX_CRC_ERR(ev[1]), .RX_FRAMING_ERR(ev[2]),
        .RX_NO_PARITY(ev[3]), .RX_FRAME_END(ev[10]), .RX_LAST_BITS(lb),
        .DESELECT_RX(ev[4]), .NVM_WR_DONE(ev[5]), .NVM_WR_FAULT(ev[6]),
        .NVM_WR_FROM_HOST(host_lvl), .NVM_ABORTED(ev[7]),
        .MASK_WR(ev[13]), .MASK_WDATA(mw), .RDATA(rdata),
        .AUX_PENDING(pend), .FIFO_PUSH_OK(push_ok), .FIFO_POP_OK(pop_ok));
    iafsf_host_model iafsf_host_model_inst (.clk(clk), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .rdata(rdata));
    task automatic print_verdict;
        $display("compared %0d, mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic fire(input logic [14:0] v);
        @(negedge clk);
        ev = v;
        @(negedge clk);
        ev = '0;
    endtask : fire
    task automatic rdc(input logic [4:0] a, input logic [7:0] e);
        iafsf_host_model_inst.read(a, d);
        chk(d, e);
    endtask : rdc
    task automatic t_reset;
        rdc(5'h0B, 8'h00);
        rdc(5'h0C, 8'h00);
        rdc(5'h09, 8'h00);
        chk({5'h00, pend, push_ok, pop_ok}, 8'h02);
        $display("t_reset done");
    endtask : t_reset
    task automatic t_flags;
        for (int i = 0; i < 8; i++) begin
            fire(EV_TBL[i]);
            fire(15'h4000);
            chk({7'h00, pend}, 8'h01);
            rdc(5'h0B, FL_TBL[i]);
            rdc(5'h0B, 8'h00);
            chk({7'h00, pend}, 8'h00);
        end
        host_lvl = 1'b0;
        fire(15'h0060);
        rdc(5'h0B, 8'h00);
        host_lvl = 1'b1;
        $display("t_flags done");
    endtask : t_flags
    task automatic t_mask;
        mw = 8'h20;
        fire(15'h2000);
        rdc(5'h09, 8'h20);
        fire(15'h0001);
        repeat (3) @(negedge clk);
        chk({7'h00, pend}, 8'h00);
        rdc(5'h0B, 8'h20);
        mw = 8'h00;
        fire(15'h2000);
        $display("t_mask done");
    endtask : t_mask
    task automatic t_fifo;
        fire(15'h1000);
        rdc(5'h0D, 8'h00);
        fire(15'h0101);
        rdc(5'h0B, 8'h20);
        rdc(5'h0C, 8'h01);
        repeat (31) fire(15'h0100);
        rdc(5'h0C, 8'h20);
        chk({6'h00, push_ok, pop_ok}, 8'h01);
        fire(15'h0100);
        rdc(5'h0C, 8'h20);
        rdc(5'h0D, 8'h20);
        rdc(5'h0B, 8'h08);
        lb = 3'h3;
        fire(15'h0408);
        rdc(5'h0D, 8'h37);
        rdc(5'h0B, 8'h40);
        repeat (32) fire(15'h0200);
        rdc(5'h0C, 8'h00);
        fire(15'h0200);
        rdc(5'h0D, 8'h77);
        fire(15'h1000);
        rdc(5'h0C, 8'h00);
        rdc(5'h0D, 8'h00);
        $display("t_fifo done");
    endtask : t_fifo
    task automatic t_defaults;
        fork
            iafsf_host_model_inst.read(5'h0B, d);
            fire(15'h0002);
        join
        rdc(5'h0B, 8'h10);
        fire(15'h0001);
        fire(15'h0800);
        rdc(5'h0B, 8'h00);
        chk({7'h00, pend}, 8'h00);
        $display("t_defaults done");
    endtask : t_defaults
    initial begin
        repeat (5000) @(posedge clk);
        bad_count++;
        print_verdict;
    end
    initial begin
        repeat (2) @(negedge clk);
        rst_n = 1'b1;
        t_reset;
        t_flags;
        t_mask;
        t_fifo;
        t_defaults;
        print_verdict;
    end
endmodule : irq_and_fifo_status_flags_tb_top
